// ### src/sbst_map.svh
`ifndef SBST_MAP_SVH
`define SBST_MAP_SVH
`define SBST_NUM_TGT    5
`define SBST_ID_W       4
`define SBST_LIST_W     20
`define SBST_RCV_W      3
`define SBST_CNT_W      20
`define SBST_GROUP_ID   4'hf
`define SBST_CMD_EXT_WR 8'h01
`define SBST_PAY_ID_REQ 8'h00
`define SBST_CRC_POLY   8'h07
`define SBST_CRC_INIT   8'h00
`define SBST_CRC_BITS   20
`define SBST_K_ABIT     0
`define SBST_K_PRIO     1
`define SBST_K_SR       2
`define SBST_K_SEC      3
`define SBST_CLK_MHZ    25
`define SBST_PERIOD_US  10000
`define SBST_POLL_TO_US 1000
`define SBST_LONG_TO_US 5000
`define SBST_WDOG_NUM   3
`define SBST_WDOG_DEN   2
`endif

// ### src/sbst_pkg.sv
`default_nettype none
package sbst_pkg;
   typedef enum logic [2:0] {
      st_idle,
      st_logic_self_test,
      st_req,
      st_collect,
      st_eval
   } sbst_state_e;
   typedef logic [1:0] sbst_arb_t;
endpackage : sbst_pkg
`default_nettype wire

// ### src/sbst_link.sv
`include "sbst_map.svh"
`default_nettype none
module sbst_link (
   input  wire logic             link_clk_in,
   input  wire logic             reset_n_in,
   input  wire logic             link_rx_valid_in,
   input  wire sbst_pkg::sbst_arb_t link_rx_arb_in,
   input  wire logic [7:0]       link_rx_cmd_in,
   input  wire logic [3:0]       link_rx_addr_in,
   input  wire logic [7:0]       link_rx_data0_in,
   input  wire logic [7:0]       link_rx_data1_in,
   input  wire logic             link_tx_ready_in,
   output logic                  link_tx_valid_out,
   output sbst_pkg::sbst_arb_t   link_tx_arb_out,
   output logic [7:0]            link_tx_cmd_out,
   output logic [3:0]            link_tx_addr_out,
   output logic [7:0]            link_tx_data0_out,
   output logic [7:0]            link_tx_data1_out,
   output logic                  rx_req_out,
   input  wire logic             rx_ack_in,
   output logic                  rx_is_reply_out,
   output logic [7:0]            rx_id_out,
   input  wire logic [3:0]       tx_req_in,
   output logic [3:0]            tx_ack_out,
   input  wire logic [7:0]       tx_state_in,
   input  wire logic [7:0]       tx_own_id_in,
   input  wire logic             mute_in
);
   function automatic logic [7:0] crc8(input logic [19:0] bits);
      logic [7:0] c;
      int         i;
      c = `SBST_CRC_INIT;
      for (i = `SBST_CRC_BITS - 1; i >= 0; i--) begin
         if (c[7] ^ bits[i]) c = {c[6:0], 1'b0} ^ `SBST_CRC_POLY;
         else c = {c[6:0], 1'b0};
      end
      return c;
   endfunction : crc8

   logic [1:0] rst_sync;
   logic [3:0] req_meta, req_sync;
   logic [1:0] ack_sync, mute_sync;
   logic       rst_n_l;
   always_ff @(posedge link_clk_in) begin
      rst_sync  <= {rst_sync[0], reset_n_in};
      req_meta  <= tx_req_in;
      req_sync  <= req_meta;
      ack_sync  <= {ack_sync[0], rx_ack_in};
      mute_sync <= {mute_sync[0], mute_in};
   end
   assign rst_n_l = rst_sync[1];

   wire [3:0]  pend = req_sync ^ tx_ack_out;
   wire [1:0]  sel  = pend[`SBST_K_ABIT] ? 2'(`SBST_K_ABIT) :
                      pend[`SBST_K_PRIO] ? 2'(`SBST_K_PRIO) :
                      pend[`SBST_K_SR]   ? 2'(`SBST_K_SR) :
                                           2'(`SBST_K_SEC);
   // A muted chip keeps its requests pending forever: it stays silent.
   wire        send = (|pend) & link_tx_ready_in & ~mute_sync[1];
   wire [7:0]  pay  = (sel == 2'(`SBST_K_SR))  ? tx_own_id_in :
                      (sel == 2'(`SBST_K_SEC)) ? `SBST_PAY_ID_REQ :
                                                 tx_state_in;
   wire [7:0]  tx_crc = crc8({`SBST_CMD_EXT_WR, `SBST_GROUP_ID, pay});
   wire [3:0]  sel_hot = 4'h1 << sel;

   always_ff @(posedge link_clk_in) begin
      if (!rst_n_l) begin
         tx_ack_out        <= '0;
         link_tx_valid_out <= 1'b0;
         link_tx_arb_out   <= '0;
         link_tx_cmd_out   <= '0;
         link_tx_addr_out  <= '0;
         link_tx_data0_out <= '0;
         link_tx_data1_out <= '0;
      end else begin
         link_tx_valid_out <= send;
         if (send) begin
            tx_ack_out        <= tx_ack_out ^ sel_hot;
            link_tx_arb_out   <= sel;
            link_tx_cmd_out   <= `SBST_CMD_EXT_WR;
            link_tx_addr_out  <= `SBST_GROUP_ID;
            link_tx_data0_out <= pay;
            link_tx_data1_out <= tx_crc;
         end
      end
   end

   wire rx_crc_ok = crc8({link_rx_cmd_in, link_rx_addr_in, link_rx_data0_in})
                    == link_rx_data1_in;
   wire rx_kind   = (link_rx_arb_in == 2'(`SBST_K_SR)) |
                    (link_rx_arb_in == 2'(`SBST_K_SEC));
   wire rx_take   = link_rx_valid_in & rx_crc_ok & rx_kind &
                    (link_rx_addr_in == `SBST_GROUP_ID) &
                    (link_rx_cmd_in == `SBST_CMD_EXT_WR) &
                    (rx_req_out == ack_sync[1]) & ~mute_sync[1];

   always_ff @(posedge link_clk_in) begin
      if (!rst_n_l) begin
         rx_req_out      <= 1'b0;
         rx_is_reply_out <= 1'b0;
         rx_id_out       <= '0;
      end else if (rx_take) begin
         rx_req_out      <= ~rx_req_out;
         rx_is_reply_out <= link_rx_arb_in == 2'(`SBST_K_SR);
         rx_id_out       <= link_rx_data0_in;
      end
   end

   property p_prio;
      @(posedge link_clk_in) disable iff (!rst_n_l)
      send && pend[`SBST_K_ABIT] |=> link_tx_valid_out &&
         link_tx_arb_out == 2'(`SBST_K_ABIT);
   endproperty
   a_prio: assert property (p_prio)
      else $error("A-bit message not sent first");
   property p_frame;
      @(posedge link_clk_in) disable iff (!rst_n_l)
      link_tx_valid_out |-> link_tx_addr_out == `SBST_GROUP_ID &&
         link_tx_data1_out == crc8({link_tx_cmd_out, link_tx_addr_out,
                                    link_tx_data0_out});
   endproperty
   a_frame: assert property (p_frame)
      else $error("Frame address or checksum wrong");
   property p_mute;
      @(posedge link_clk_in) disable iff (!rst_n_l)
      mute_sync[1] && $past(mute_sync[1]) |-> !link_tx_valid_out;
   endproperty
   a_mute: assert property (p_mute)
      else $error("Muted link transmitted");
endmodule : sbst_link
`default_nettype wire

// ### src/sbst_top.sv
`include "sbst_map.svh"
`default_nettype none
module sbst_top #(
   parameter logic [`SBST_CNT_W-1:0] PERIOD_CYC =
      `SBST_CNT_W'(`SBST_PERIOD_US * `SBST_CLK_MHZ),
   parameter logic [`SBST_CNT_W-1:0] POLL_TO_CYC =
      `SBST_CNT_W'(`SBST_POLL_TO_US * `SBST_CLK_MHZ),
   parameter logic [`SBST_CNT_W-1:0] LONG_TO_CYC =
      `SBST_CNT_W'(`SBST_LONG_TO_US * `SBST_CLK_MHZ)
) (
   input  wire logic                   core_clk_in,
   input  wire logic                   reset_n_in,
   input  wire logic                   link_clk_in,
   input  wire logic                   role_controller_in,
   input  wire logic [`SBST_ID_W-1:0]  own_id_in,
   input  wire logic [`SBST_LIST_W-1:0] expected_ids_in,
   input  wire logic                   boot_state_in,
   input  wire logic                   mission_state_in,
   input  wire logic                   safe_recovery_in,
   output logic                        logic_self_test_start_out,
   input  wire logic                   logic_self_test_done_in,
   input  wire logic                   logic_self_test_pass_in,
   input  wire logic                   state_msg_valid_in,
   input  wire logic [7:0]             state_msg_in,
   output logic                        state_msg_ready_out,
   output logic                        self_test_busy_out,
   output logic                        self_test_pass_out,
   output logic                        self_test_fail_out,
   output logic [`SBST_NUM_TGT-1:0]    missing_mask_out,
   output logic                        bus_error_out,
   input  wire logic                   link_rx_valid_in,
   input  wire sbst_pkg::sbst_arb_t    link_rx_arb_in,
   input  wire logic [7:0]             link_rx_cmd_in,
   input  wire logic [3:0]             link_rx_addr_in,
   input  wire logic [7:0]             link_rx_data0_in,
   input  wire logic [7:0]             link_rx_data1_in,
   input  wire logic                   link_tx_ready_in,
   output logic                        link_tx_valid_out,
   output sbst_pkg::sbst_arb_t         link_tx_arb_out,
   output logic [7:0]                  link_tx_cmd_out,
   output logic [3:0]                  link_tx_addr_out,
   output logic [7:0]                  link_tx_data0_out,
   output logic [7:0]                  link_tx_data1_out
);
   // The target watchdog allows one and a half self-test periods.
   localparam logic [`SBST_CNT_W-1:0] WDOG_CYC = `SBST_CNT_W'(
      (32'(PERIOD_CYC) * `SBST_WDOG_NUM) / `SBST_WDOG_DEN);

   function automatic logic [`SBST_RCV_W-1:0] same_count(
      input logic [`SBST_LIST_W-1:0] list,
      input logic [`SBST_ID_W-1:0]   id);
      logic [`SBST_RCV_W-1:0] n;
      int                     j;
      n = '0;
      for (j = 0; j < `SBST_NUM_TGT; j++) begin
         if (list[j*`SBST_ID_W +: `SBST_ID_W] == id) n = n + 1'b1;
      end
      return n;
   endfunction : same_count

   sbst_pkg::sbst_state_e      state, next_state;
   logic                       rx_req_l, rx_is_reply, rx_ack;
   logic [7:0]                 rx_id;
   logic [1:0]                 rx_req_sync;
   logic [3:0]                 tx_req, tx_ack_l, tx_ack_meta, tx_ack_sync;
   logic [7:0]                 state_msg;
   logic [`SBST_LIST_W-1:0]    exp_list;
   logic [`SBST_CNT_W-1:0]     timer, per_cnt, wd_cnt;
   logic                       ran, err_unknown;
   logic [`SBST_ID_W-1:0]      ent_id   [`SBST_NUM_TGT];
   logic [`SBST_RCV_W-1:0]     ent_exp  [`SBST_NUM_TGT];
   logic [`SBST_RCV_W-1:0]     recv     [`SBST_NUM_TGT];
   logic [`SBST_NUM_TGT-1:0]   ent_hit, ent_miss, ent_over;

   sbst_link u_link (
      .link_clk_in       (link_clk_in),
      .reset_n_in        (reset_n_in),
      .link_rx_valid_in  (link_rx_valid_in),
      .link_rx_arb_in    (link_rx_arb_in),
      .link_rx_cmd_in    (link_rx_cmd_in),
      .link_rx_addr_in   (link_rx_addr_in),
      .link_rx_data0_in  (link_rx_data0_in),
      .link_rx_data1_in  (link_rx_data1_in),
      .link_tx_ready_in  (link_tx_ready_in),
      .link_tx_valid_out (link_tx_valid_out),
      .link_tx_arb_out   (link_tx_arb_out),
      .link_tx_cmd_out   (link_tx_cmd_out),
      .link_tx_addr_out  (link_tx_addr_out),
      .link_tx_data0_out (link_tx_data0_out),
      .link_tx_data1_out (link_tx_data1_out),
      .rx_req_out        (rx_req_l),
      .rx_ack_in         (rx_ack),
      .rx_is_reply_out   (rx_is_reply),
      .rx_id_out         (rx_id),
      .tx_req_in         (tx_req),
      .tx_ack_out        (tx_ack_l),
      .tx_state_in       (state_msg),
      .tx_own_id_in      ({4'h0, own_id_in}),
      .mute_in           (bus_error_out)
   );

   // Link words are held by the link until the toggle is acknowledged.
   always_ff @(posedge core_clk_in) begin
      rx_req_sync <= {rx_req_sync[0], rx_req_l};
      tx_ack_meta <= tx_ack_l;
      tx_ack_sync <= tx_ack_meta;
   end

   wire       rx_evt      = rx_req_sync[1] ^ rx_ack;
   wire       reply_evt   = rx_evt & rx_is_reply;
   wire       request_evt = rx_evt & ~rx_is_reply;
   wire [3:0] tx_pend     = tx_req ^ tx_ack_sync;
   wire       active      = boot_state_in | mission_state_in;
   wire       long_to     = boot_state_in | safe_recovery_in;
   wire       in_collect  = state == sbst_pkg::st_collect;
   wire       timed_out   = in_collect & (timer == '0);
   wire       start_test  = role_controller_in & active & ~bus_error_out &
                            (~ran | per_cnt == '0);
   wire       logic_self_test_fail  = state == sbst_pkg::st_logic_self_test &
                            logic_self_test_done_in & ~logic_self_test_pass_in;
   wire       eval_pass   = ~(|ent_miss) & ~(|ent_over) & ~err_unknown;
   wire       eval_fail   = state == sbst_pkg::st_eval & ~eval_pass;
   wire       wd_on       = ~role_controller_in & active & ~bus_error_out;
   wire       wd_expire   = wd_on & (wd_cnt == '0);
   wire       unknown_id  = reply_evt & in_collect & ~(|ent_hit);

   assign state_msg_ready_out = ~tx_pend[`SBST_K_ABIT] &
                                ~tx_pend[`SBST_K_PRIO] & ~bus_error_out;
   wire       msg_take = state_msg_valid_in & state_msg_ready_out;
   wire [3:0] tx_set;
   assign tx_set[`SBST_K_ABIT] = msg_take & ~role_controller_in;
   assign tx_set[`SBST_K_PRIO] = msg_take & role_controller_in;
   assign tx_set[`SBST_K_SR]   = request_evt & ~tx_pend[`SBST_K_SR] &
                                 ~bus_error_out;
   assign tx_set[`SBST_K_SEC]  = state == sbst_pkg::st_req;
   assign self_test_busy_out   = state != sbst_pkg::st_idle;

   always_comb begin
      next_state = state;
      unique case (state)
         sbst_pkg::st_idle:
            if (start_test) next_state = sbst_pkg::st_logic_self_test;
         sbst_pkg::st_logic_self_test:
            if (logic_self_test_done_in) begin
               next_state = logic_self_test_pass_in ? sbst_pkg::st_req :
                            sbst_pkg::st_idle;
            end
         sbst_pkg::st_req:
            next_state = sbst_pkg::st_collect;
         sbst_pkg::st_collect:
            if (timer == '0) next_state = sbst_pkg::st_eval;
         sbst_pkg::st_eval:
            next_state = sbst_pkg::st_idle;
      endcase
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         state  <= sbst_pkg::st_idle;
         rx_ack <= 1'b0;
         tx_req <= '0;
      end else begin
         state  <= next_state;
         rx_ack <= rx_ack ^ rx_evt;
         tx_req <= tx_req ^ tx_set;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) state_msg <= '0;
      else if (msg_take) state_msg <= state_msg_in;
   end

   // The list is captured per test so it stays stable while counting.
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         exp_list <= '0;
         ran      <= 1'b0;
      end else if (state == sbst_pkg::st_idle && start_test) begin
         exp_list <= expected_ids_in;
         ran      <= 1'b1;
      end
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) logic_self_test_start_out <= 1'b0;
      else logic_self_test_start_out <= state == sbst_pkg::st_idle &&
                                        start_test;
   end

   // Timeout runs from the cycle the broadcast request is issued.
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) timer <= '0;
      else if (state == sbst_pkg::st_req)
         timer <= long_to ? LONG_TO_CYC : POLL_TO_CYC;
      else if (in_collect && timer != '0) timer <= timer - 1'b1;
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || state == sbst_pkg::st_eval) per_cnt <= PERIOD_CYC;
      else if (state == sbst_pkg::st_idle && active && per_cnt != '0)
         per_cnt <= per_cnt - 1'b1;
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || !wd_on || request_evt) wd_cnt <= WDOG_CYC;
      else if (wd_cnt != '0) wd_cnt <= wd_cnt - 1'b1;
   end

   genvar gi;
   generate
      for (gi = 0; gi < `SBST_NUM_TGT; gi++) begin : g_ent
         assign ent_id[gi]   = exp_list[gi*`SBST_ID_W +: `SBST_ID_W];
         assign ent_exp[gi]  = same_count(exp_list, ent_id[gi]);
         assign ent_hit[gi]  = reply_evt & (ent_id[gi] != '0) &
                               (rx_id == {4'h0, ent_id[gi]});
         // A zero entry expects nothing and never matches.
         assign ent_miss[gi] = (ent_id[gi] != '0) &
                               (recv[gi] < ent_exp[gi]);
         assign ent_over[gi] = (ent_id[gi] != '0) &
                               (recv[gi] > ent_exp[gi]);
         always_ff @(posedge core_clk_in) begin
            if (!reset_n_in || state == sbst_pkg::st_req) recv[gi] <= '0;
            else if (ent_hit[gi] && in_collect && recv[gi] != '1)
               recv[gi] <= recv[gi] + 1'b1;
         end
      end
   endgenerate

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in || state == sbst_pkg::st_req) err_unknown <= 1'b0;
      else if (unknown_id) err_unknown <= 1'b1;
   end

   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) begin
         self_test_pass_out <= 1'b0;
         self_test_fail_out <= 1'b0;
         missing_mask_out   <= '0;
      end else if (state == sbst_pkg::st_eval) begin
         self_test_pass_out <= eval_pass;
         self_test_fail_out <= ~eval_pass;
         missing_mask_out   <= ent_miss;
      end else if (logic_self_test_fail) begin
         self_test_pass_out <= 1'b0;
         self_test_fail_out <= 1'b1;
      end
   end

   // Sticky until power-on reset; it also silences the link.
   always_ff @(posedge core_clk_in) begin
      if (!reset_n_in) bus_error_out <= 1'b0;
      else if (eval_fail || logic_self_test_fail || wd_expire)
         bus_error_out <= 1'b1;
   end

   property p_logic_self_test_first;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      state == sbst_pkg::st_req |-> $past(state) == sbst_pkg::st_logic_self_test &&
         $past(logic_self_test_pass_in);
   endproperty
   a_logic_self_test_first: assert property (p_logic_self_test_first)
      else $error("Bus test started without passing logic test");
   property p_request;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      state == sbst_pkg::st_req |=> tx_pend[`SBST_K_SEC] ##1
         in_collect;
   endproperty
   a_request: assert property (p_request)
      else $error("Identifier request not issued");
   property p_reply;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      request_evt && !bus_error_out |=> tx_pend[`SBST_K_SR] [*2];
   endproperty
   a_reply: assert property (p_reply)
      else $error("Identifier reply not requested");
   property p_timeout_len;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      state == sbst_pkg::st_req && long_to |=> timer == LONG_TO_CYC;
   endproperty
   a_timeout_len: assert property (p_timeout_len)
      else $error("Long timeout not applied");
   property p_fail_err;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      eval_fail |=> bus_error_out && self_test_fail_out &&
         !self_test_pass_out;
   endproperty
   a_fail_err: assert property (p_fail_err)
      else $error("Failed test did not raise bus error");
   property p_unknown;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      unknown_id |=> err_unknown [*2];
   endproperty
   a_unknown: assert property (p_unknown)
      else $error("Unexpected identifier not caught");
   property p_wdog;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      wd_expire |=> bus_error_out ##1 !state_msg_ready_out;
   endproperty
   a_wdog: assert property (p_wdog)
      else $error("Missing request did not raise bus error");
   property p_sticky;
      @(posedge core_clk_in) disable iff (!reset_n_in)
      bus_error_out |=> bus_error_out && !logic_self_test_start_out;
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("Bus error cleared or test restarted");
endmodule : sbst_top
`default_nettype wire

// ### test/sbst_far_end.sv
`default_nettype none
module sbst_far_end (
   input  wire logic                link_clk_in,
   input  wire logic                tx_valid_in,
   input  wire sbst_pkg::sbst_arb_t tx_arb_in,
   input  wire logic [11:0]         ids_in,
   input  wire logic [1:0]          n_in,
   input  wire logic [7:0]          dly_in,
   output logic                     ready_out,
   output logic                     v_out,
   output sbst_pkg::sbst_arb_t      arb_out,
   output logic [7:0]               cmd_out,
   output logic [3:0]               addr_out,
   output logic [7:0]               d0_out,
   output logic [7:0]               d1_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] wait_q;
   logic [1:0] sent;
   logic [3:0] id_sel;
   function automatic logic [7:0] crc8(input logic [19:0] m);
      logic [7:0] c;
      c = 8'h00;
      for (int i = 19; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction : crc8
   assign ready_out = 1'b1;
   assign id_sel = ids_in[sent*4 +: 4];
   initial begin
      {v_out, arb_out, cmd_out, addr_out, d0_out, d1_out, wait_q} = '0;
      sent = 2'h3;
   end
   // Between frames the data lines toggle every cycle between the last frame's data and its inverse.
   always @(posedge link_clk_in) begin
      v_out <= 1'b0;
      {cmd_out, addr_out, d0_out, d1_out} <= ~{cmd_out, addr_out, d0_out, d1_out};
      if (tx_valid_in && tx_arb_in == 2'h3) begin
         wait_q <= dly_in;
         sent <= 2'h0;
      end else if (wait_q != 8'h00) begin
         wait_q <= wait_q - 8'h01;
      end else if (sent < n_in) begin
         v_out <= 1'b1;
         arb_out <= 2'h2;
         cmd_out <= 8'h01;
         addr_out <= 4'hf;
         d0_out <= {4'h0, id_sel};
         d1_out <= crc8({8'h01, 4'hf, 4'h0, id_sel});
         sent <= sent + 2'h1;
         wait_q <= 8'h04;
      end
   end
endmodule : sbst_far_end
`default_nettype wire

// ### test/sbst_top_tb_top.sv
`default_nettype none
module sbst_top_tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic core_clk_in = 0, link_clk_in = 0, reset_n_in = 0, role = 1;
   logic boot = 0, mission = 1, done = 0, pass = 0, safe = 0, sm_v = 0;
   logic [7:0]  sm_d = '0;
   logic [19:0] exp_ids = '0;
   logic [11:0] rep_ids = '0;
   logic [1:0]  rep_n = '0;
   logic [7:0]  rep_dly = '0;
   logic st_start, busy, t_pass, t_fail, bus_err, tx_v, rx_v, rdy, sm_rdy;
   logic [4:0]  miss;
   sbst_pkg::sbst_arb_t tx_arb, rx_arb;
   logic [7:0]  tx_cmd, tx_d0, tx_d1, rx_cmd, rx_d0, rx_d1;
   logic [3:0]  tx_addr, rx_addr;
   int num_errors = 0, n_compared = 0, cnt;
   initial forever #20 core_clk_in = ~core_clk_in;
   initial begin
      #7;
      forever #40 link_clk_in = ~link_clk_in;
   end
   sbst_top #(.PERIOD_CYC(20'd200), .POLL_TO_CYC(20'd40),
      .LONG_TO_CYC(20'd80)) sbst_top_inst (.core_clk_in, .reset_n_in,
      .link_clk_in, .role_controller_in(role), .own_id_in(4'h5),
      .expected_ids_in(exp_ids), .boot_state_in(boot),
      .mission_state_in(mission), .safe_recovery_in(safe),
      .logic_self_test_start_out(st_start), .logic_self_test_done_in(done),
      .logic_self_test_pass_in(pass), .state_msg_valid_in(sm_v),
      .state_msg_in(sm_d), .state_msg_ready_out(sm_rdy),
      .self_test_busy_out(busy), .self_test_pass_out(t_pass),
      .self_test_fail_out(t_fail), .missing_mask_out(miss),
      .bus_error_out(bus_err), .link_rx_valid_in(rx_v),
      .link_rx_arb_in(rx_arb), .link_rx_cmd_in(rx_cmd),
      .link_rx_addr_in(rx_addr), .link_rx_data0_in(rx_d0),
      .link_rx_data1_in(rx_d1), .link_tx_ready_in(rdy),
      .link_tx_valid_out(tx_v), .link_tx_arb_out(tx_arb),
      .link_tx_cmd_out(tx_cmd), .link_tx_addr_out(tx_addr),
      .link_tx_data0_out(tx_d0), .link_tx_data1_out(tx_d1));
   sbst_far_end sbst_far_end_inst (.link_clk_in, .tx_valid_in(tx_v),
      .tx_arb_in(tx_arb), .ids_in(rep_ids), .n_in(rep_n), .dly_in(rep_dly),
      .ready_out(rdy), .v_out(rx_v), .arb_out(rx_arb), .cmd_out(rx_cmd),
      .addr_out(rx_addr), .d0_out(rx_d0), .d1_out(rx_d1));
   task automatic stop_test;
      $display("errors %0d compared %0d", num_errors, n_compared);
      if (num_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Counts core cycles until the signal reaches the level; ends run on hang.
   task automatic wait_lvl(ref logic s, input logic lv, input int lim);
      for (cnt = 0; s !== lv; cnt++) begin
         if (cnt == lim) begin
            num_errors++;
            stop_test();
         end
         @(negedge core_clk_in);
      end
   endtask : wait_lvl
   task automatic do_reset;
      reset_n_in = 0;
      repeat (10) @(negedge core_clk_in);
      reset_n_in = 1;
   endtask : do_reset
   task automatic run_bist(input logic [19:0] e, input logic [11:0] r,
      input logic [1:0] n, input logic [7:0] dly, input logic lb,
      input logic ok, input logic [4:0] m);
      {exp_ids, rep_ids, rep_n, rep_dly} = {e, r, n, dly};
      // A failed test leaves the bus error set; a late reply drains first.
      if (bus_err) begin
         repeat (40) @(negedge core_clk_in);
         do_reset();
      end
      wait_lvl(st_start, 1'b1, 400);
      @(negedge core_clk_in);
      {done, pass} = {1'b1, lb};
      @(negedge core_clk_in);
      done = 0;
      if (lb) begin
         wait_lvl(tx_v, 1'b1, 20);
         chk({tx_arb, tx_cmd, tx_addr, tx_d0}, {2'h3, 8'h01, 4'hf, 8'h00});
         chk(tx_d1, sbst_far_end_inst.crc8(20'h01f00));
      end
      wait_lvl(busy, 1'b0, 300);
      @(negedge core_clk_in);
      chk({t_pass, t_fail}, {ok, !ok});
      if (lb) chk(miss, m);
      else chk(bus_err, 1'b1);
      chk(bus_err, !ok);
   endtask : run_bist
   task automatic send_msg(input logic [7:0] d);
      {sm_v, sm_d} = {1'b1, d};
      @(negedge core_clk_in);
      {sm_v, sm_d} = {1'b0, 8'h00};
      chk(sm_rdy, 1'b0);
      wait_lvl(tx_v, 1'b1, 20);
      chk({tx_arb, tx_d0}, {2'h1, d});
      chk(tx_d1, sbst_far_end_inst.crc8({12'h01f, d}));
      wait_lvl(sm_rdy, 1'b1, 20);
      chk(sm_rdy, 1'b1);
   endtask : send_msg
   initial begin
      do_reset();
      run_bist(20'h000c3, 12'h0c3, 2'd2, 8'd2, 1, 1, 5'h00);
      wait_lvl(st_start, 1'b1, 400);
      chk(cnt >= 200 && cnt <= 206, 1);
      run_bist(20'h000c3, 12'h003, 2'd1, 8'd2, 1, 0, 5'h02);
      run_bist(20'h00003, 12'h033, 2'd2, 8'd2, 1, 0, 5'h00);
      run_bist(20'h00033, 12'h033, 2'd2, 8'd2, 1, 1, 5'h00);
      run_bist(20'h00000, 12'h000, 2'd0, 8'd2, 1, 1, 5'h00);
      send_msg(8'h5a);
      run_bist(20'h00000, 12'h005, 2'd1, 8'd2, 1, 0, 5'h00);
      run_bist(20'h00003, 12'h003, 2'd1, 8'd30, 1, 0, 5'h01);
      {boot, mission} = 2'b10;
      run_bist(20'h00003, 12'h003, 2'd1, 8'd30, 1, 1, 5'h00);
      {boot, mission, safe} = 3'b011;
      run_bist(20'h00003, 12'h003, 2'd1, 8'd30, 1, 1, 5'h00);
      run_bist(20'h00003, 12'h003, 2'd1, 8'd2, 0, 0, 5'h00);
      {role, boot, mission} = 3'b001;
      do_reset();
      wait_lvl(bus_err, 1'b1, 400);
      chk(cnt >= 299 && cnt <= 306, 1);
      stop_test();
   end
endmodule : sbst_top_tb_top
`default_nettype wire
